// ==== tcmp_timer.sv ====
`timescale 1ns/1ps
// Function
// - force strobe updates output, no flag/clear
// - counter write blocks next-tick compare matches
// - counter loaded with top skips that match
// - output register kept across mode changes
// - output action bits act immediately, unbuffered
// - reset clears output register to zero
// - nonzero action replaces port value on pin
// - action zero leaves output register unchanged
// - action bits never touch capture logic
// - counting depends only on generation mode
// - normal mode counts up, wraps at max
// - overflow flag set as counter wraps from max to zero
// - clear-on-match clears at A or capture
// - top match sets A or capture flag
// - no top buffering; missed top wraps first
// - toggle action halves match frequency
// - clear-on-match overflow set at max wrap
// - timer clock prescale 1/8/64/256/1024
// - match sets compare flag next tick
// - high byte staged, low write commits both
// - compare writes unbuffered in these modes
// - compare flag cleared by ack or one-write
module tcmp_timer
    import tcmp_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        capture_pin,
    input  wire logic        ovf_int_ack,
    input  wire logic        cmpa_int_ack,
    input  wire logic        cmpb_int_ack,
    input  wire logic        cap_int_ack,
    output logic [3:0]       flags,
    output logic             pin_a_out,
    output logic             pin_a_oe,
    output logic             pin_b_out,
    output logic             pin_b_oe
);

    typedef struct packed {
        tcmp_ctrl_t  ctrl;
        logic [15:0] timer_count;
        logic [15:0] compare_value_a;
        logic [15:0] compare_value_b;
        logic [15:0] capture_value;
        logic [7:0]  temp_hi;
        logic        block_match;
        logic [3:0]  flag;
        logic [1:0]  compare_output_reg;
        logic [3:0]  port;
        logic        pin_a_out;
        logic        pin_a_oe;
        logic        pin_b_out;
        logic        pin_b_oe;
        logic [2:0]  cap_sync;
    } tcmp_state_t;

    tcmp_state_t r;
    tcmp_state_t next_r;
    logic        tick;
    logic        wr_en;
    tcmp_wr_t    wr;
    logic        wr_ok;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_ok;
    logic        ctc_mode;
    logic [15:0] top;
    logic        top_hit;
    logic [1:0]  match;
    logic [1:0]  force_strobe;
    logic [1:0]  com [2];
    logic        cap_edge;
    logic [3:0]  flag_clr;
    logic [3:0]  flag_set;

    ////////////////////////////////////////////////////////////////////////////
    tcmp_prescale u_prescale
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .presc   (r.ctrl.presc),
        .tick    (tick)
    );

    tcmp_axil u_axil
    (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_en         (wr_en),
        .wr            (wr),
        .wr_ok         (wr_ok),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_ok         (rd_ok)
    );

    ////////////////////////////////////////////////////////////////////////////
    assign ctc_mode = (r.ctrl.wgm == WGM_CTC_CMPA) || (r.ctrl.wgm == WGM_CTC_CAP);
    // top comes straight from the live register, no buffer
    assign top      = (r.ctrl.wgm == WGM_CTC_CAP) ? r.capture_value : r.compare_value_a;
    // compare hits are suppressed one tick after a counter write
    assign match[0] = (r.timer_count == r.compare_value_a) && !r.block_match;
    assign match[1] = (r.timer_count == r.compare_value_b) && !r.block_match;
    assign top_hit  = ctc_mode && (r.timer_count == top) && !r.block_match;
    assign com[0]   = r.ctrl.com_a;
    assign com[1]   = r.ctrl.com_b;
    assign force_strobe[0] = wr_en && (wr.addr == ADDR_STROBE) && wr.strb[0] && wr.data[STRB_FORCE_A];
    assign force_strobe[1] = wr_en && (wr.addr == ADDR_STROBE) && wr.strb[0] && wr.data[STRB_FORCE_B];
    // capture edge sees only synchronised pin, never action bits
    assign cap_edge = r.cap_sync[1] && !r.cap_sync[2] && (r.ctrl.wgm != WGM_CTC_CAP);
    assign flag_clr = (wr_en && (wr.addr == ADDR_FLAGS) && wr.strb[0]) ? wr.data[3:0] : 4'h0;

    always_comb
    begin
        case (wr.addr)
            ADDR_CTRL, ADDR_COUNT, ADDR_CMP_HI, ADDR_CMP_A_LO, ADDR_CMP_B_LO,
            ADDR_CAPTURE, ADDR_FLAGS, ADDR_STROBE, ADDR_PORT: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
        rd_ok = 1'b1;
        case (rd_addr)
            ADDR_CTRL:     rd_data = {21'h0, r.ctrl.presc, r.ctrl.com_b, r.ctrl.com_a, r.ctrl.wgm};
            ADDR_COUNT:    rd_data = {16'h0, r.timer_count};
            ADDR_CMP_HI:   rd_data = {24'h0, r.temp_hi};
            ADDR_CMP_A_LO: rd_data = {16'h0, r.compare_value_a};
            ADDR_CMP_B_LO: rd_data = {16'h0, r.compare_value_b};
            ADDR_CAPTURE:  rd_data = {16'h0, r.capture_value};
            ADDR_FLAGS:    rd_data = {28'h0, r.flag};
            ADDR_STROBE:   rd_data = RESET_WORD;
            ADDR_PORT:     rd_data = {26'h0, r.compare_output_reg, r.port};
            default:
            begin
                rd_data = RESET_WORD;
                rd_ok   = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_r = r;
        flag_set = 4'h0;
        next_r.cap_sync = {r.cap_sync[1:0], capture_pin};

        // counter: sequence chosen by generation mode alone
        if (tick)
        begin
            next_r.block_match = 1'b0;
            if (top_hit)
                next_r.timer_count = COUNT_BOTTOM;
            else
                next_r.timer_count = r.timer_count + 16'h0001;
            // wrap from max sets overflow with zero count
            // match flags rise with the output update
            flag_set = {top_hit && (r.ctrl.wgm == WGM_CTC_CAP), match, r.timer_count == COUNT_MAX};
        end

        // output waveform on match or force; mode changes leave it be
        for (int i = 0; i < 2; i++)
        begin
            if ((tick && match[i]) || force_strobe[i])
            begin
                case (com[i])
                    COM_TOGGLE: next_r.compare_output_reg[i] = !r.compare_output_reg[i];
                    COM_CLEAR:  next_r.compare_output_reg[i] = 1'b0;
                    COM_SET:    next_r.compare_output_reg[i] = 1'b1;
                    default:    next_r.compare_output_reg[i] = r.compare_output_reg[i];
                endcase
            end
        end

        if (cap_edge)
        begin
            next_r.capture_value   = r.timer_count;
            flag_set[FLAG_CAP]     = 1'b1;
        end

        // clears by ack or one-write; a set in the same cycle wins
        next_r.flag = (r.flag & ~(flag_clr | {cap_int_ack, cmpb_int_ack, cmpa_int_ack, ovf_int_ack})) | flag_set;

        if (wr_en && wr.strb[0])
        begin
            case (wr.addr)
                ADDR_CTRL:
                begin
                    next_r.ctrl.wgm   = wr.data[CTRL_WGM_LSB +: 4];
                    next_r.ctrl.com_a = wr.data[CTRL_COMA_LSB +: 2];
                    next_r.ctrl.com_b = wr.data[CTRL_COMB_LSB +: 2];
                end
                ADDR_COUNT:
                begin
                    next_r.timer_count = {r.temp_hi, wr.data[7:0]};
                    next_r.block_match = 1'b1;
                end
                ADDR_CMP_HI:   next_r.temp_hi = wr.data[7:0];
                ADDR_CMP_A_LO: next_r.compare_value_a = {r.temp_hi, wr.data[7:0]};
                ADDR_CMP_B_LO: next_r.compare_value_b = {r.temp_hi, wr.data[7:0]};
                ADDR_CAPTURE:
                    if (r.ctrl.wgm == WGM_CTC_CAP)
                        next_r.capture_value = {r.temp_hi, wr.data[7:0]};
                ADDR_PORT:     next_r.port = wr.data[3:0];
                default:       next_r.port = r.port;
            endcase
        end
        if (wr_en && wr.strb[1] && wr.addr == ADDR_CTRL)
            next_r.ctrl.presc = wr.data[CTRL_PRESC_LSB +: 3];

        // pin mux: nonzero action overrides port, direction stays with port bit
        next_r.pin_a_out = (r.ctrl.com_a != COM_OFF) ? r.compare_output_reg[0] : r.port[PORT_VAL_A];
        next_r.pin_b_out = (r.ctrl.com_b != COM_OFF) ? r.compare_output_reg[1] : r.port[PORT_VAL_B];
        next_r.pin_a_oe  = r.port[PORT_DIR_A];
        next_r.pin_b_oe  = r.port[PORT_DIR_B];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r <= '0;
        else
            r <= next_r;
    end

    assign flags     = r.flag;
    assign pin_a_out = r.pin_a_out;
    assign pin_a_oe  = r.pin_a_oe;
    assign pin_b_out = r.pin_b_out;
    assign pin_b_oe  = r.pin_b_oe;

endmodule

// ==== tcmp_pkg.sv ====
package tcmp_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_COUNT     = 8'h04;
    localparam logic [7:0] ADDR_CMP_HI    = 8'h08;
    localparam logic [7:0] ADDR_CMP_A_LO  = 8'h0C;
    localparam logic [7:0] ADDR_CMP_B_LO  = 8'h10;
    localparam logic [7:0] ADDR_CAPTURE   = 8'h14;
    localparam logic [7:0] ADDR_FLAGS     = 8'h18;
    localparam logic [7:0] ADDR_STROBE    = 8'h1C;
    localparam logic [7:0] ADDR_PORT      = 8'h20;

    // control field positions
    localparam int CTRL_WGM_LSB   = 0;
    localparam int CTRL_COMA_LSB  = 4;
    localparam int CTRL_COMB_LSB  = 6;
    localparam int CTRL_PRESC_LSB = 8;

    // flag positions
    localparam int FLAG_OVF  = 0;
    localparam int FLAG_CMPA = 1;
    localparam int FLAG_CMPB = 2;
    localparam int FLAG_CAP  = 3;

    // strobe and port positions
    localparam int STRB_FORCE_A = 0;
    localparam int STRB_FORCE_B = 1;
    localparam int PORT_VAL_A   = 0;
    localparam int PORT_VAL_B   = 1;
    localparam int PORT_DIR_A   = 2;
    localparam int PORT_DIR_B   = 3;

    localparam logic [3:0]  WGM_NORMAL   = 4'h0;
    localparam logic [3:0]  WGM_CTC_CMPA = 4'h4;
    localparam logic [3:0]  WGM_CTC_CAP  = 4'hC;
    localparam logic [1:0]  COM_OFF      = 2'h0;
    localparam logic [1:0]  COM_TOGGLE   = 2'h1;
    localparam logic [1:0]  COM_CLEAR    = 2'h2;
    localparam logic [1:0]  COM_SET      = 2'h3;
    localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // prescale selects: 0 stop, 1 div1, 2 div8, 3 div64, 4 div256, 5 div1024
    localparam logic [2:0]  PRESC_STOP   = 3'h0;
    localparam logic [9:0]  DIV_8_MASK    = 10'h007;
    localparam logic [9:0]  DIV_64_MASK   = 10'h03F;
    localparam logic [9:0]  DIV_256_MASK  = 10'h0FF;
    localparam logic [9:0]  DIV_1024_MASK = 10'h3FF;

    typedef struct packed {
        logic [3:0] wgm;
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic [2:0] presc;
    } tcmp_ctrl_t;

    typedef struct packed {
        logic [7:0]  awaddr;
        logic        aw_full;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        w_full;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tcmp_bus_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } tcmp_wr_t;

endpackage

// ==== tcmp_prescale.sv ====
`timescale 1ns/1ps
module tcmp_prescale
    import tcmp_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [2:0] presc,
    output logic            tick
);

    typedef struct packed {
        logic [9:0] div;
        logic       tick;
    } tcmp_presc_state_t;

    tcmp_presc_state_t r;
    tcmp_presc_state_t next_r;
    logic [9:0]        mask;

    always_comb
    begin
        next_r = r;
        case (presc)
            3'h1:    mask = 10'h000;
            3'h2:    mask = DIV_8_MASK;
            3'h3:    mask = DIV_64_MASK;
            3'h4:    mask = DIV_256_MASK;
            default: mask = DIV_1024_MASK;
        endcase
        next_r.div  = r.div + 10'h001;
        // selected division 1/8/64/256/1024
        next_r.tick = (presc != PRESC_STOP) && (presc <= 3'h5) && ((r.div & mask) == 10'h000);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r <= '0;
        else
            r <= next_r;
    end

    assign tick = r.tick;

endmodule

// ==== tcmp_axil.sv ====
`timescale 1ns/1ps
module tcmp_axil
    import tcmp_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             wr_en,
    output tcmp_wr_t         wr,
    input  wire logic        wr_ok,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_ok
);

    tcmp_bus_t r;
    tcmp_bus_t next_r;
    logic      do_wr;
    logic      do_rd;

    // write fires once both halves are held and no response is pending
    assign do_wr = r.aw_full && r.w_full && !r.bvalid;
    assign do_rd = s_axi_arvalid && !r.rvalid;

    always_comb
    begin
        next_r = r;
        if (s_axi_awvalid && !r.aw_full)
        begin
            next_r.aw_full = 1'b1;
            next_r.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_full)
        begin
            next_r.w_full = 1'b1;
            next_r.wdata  = s_axi_wdata;
            next_r.wstrb  = s_axi_wstrb;
        end
        if (do_wr)
        begin
            next_r.aw_full = 1'b0;
            next_r.w_full  = 1'b0;
            next_r.bvalid  = 1'b1;
            next_r.bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (r.bvalid && s_axi_bready)
            next_r.bvalid = 1'b0;
        if (do_rd)
        begin
            next_r.rvalid = 1'b1;
            next_r.rdata  = rd_ok ? rd_data : RESET_WORD;
            next_r.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (r.rvalid && s_axi_rready)
            next_r.rvalid = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            r <= '0;
        else
            r <= next_r;
    end

    assign s_axi_awready = !r.aw_full;
    assign s_axi_wready  = !r.w_full;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;
    assign wr_en         = do_wr;
    assign wr.addr       = r.awaddr;
    assign wr.data       = r.wdata;
    assign wr.strb       = r.wstrb;
    assign rd_addr       = s_axi_araddr;

endmodule

// ==== tcmp_timer_assertions.sv ====
`timescale 1ns/1ps
module tcmp_timer_checker
    import tcmp_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_wvalid,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        ovf_int_ack,
    input wire logic        cmpa_int_ack,
    input wire logic [3:0]  flags,
    input wire logic        pin_a_out,
    input wire logic        pin_a_oe,
    input wire logic        pin_b_out
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_reset_out;
        disable iff (1'b0) !aresetn ##1 !aresetn |-> flags == 4'h0 && !pin_a_out && !pin_b_out;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not cleared in reset");

    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");

    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read response dropped");

    property p_rnext;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rnext: assert property (p_rnext) else $error("read answer late");

    property p_bcause;
        $rose(s_axi_bvalid) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2);
    endproperty
    a_bcause: assert property (p_bcause) else $error("write answer without data");

    property p_slverr_zero;
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000;
    endproperty
    a_slverr_zero: assert property (p_slverr_zero) else $error("refused read data not zero");

    property p_ovf_fall;
        $fell(flags[FLAG_OVF]) |-> $past(ovf_int_ack) || s_axi_bvalid || $past(s_axi_bvalid);
    endproperty
    a_ovf_fall: assert property (p_ovf_fall) else $error("overflow flag cleared by itself");

    property p_cmpa_fall;
        $fell(flags[FLAG_CMPA]) |-> $past(cmpa_int_ack) || s_axi_bvalid || $past(s_axi_bvalid);
    endproperty
    a_cmpa_fall: assert property (p_cmpa_fall) else $error("compare flag cleared by itself");

    property p_oe_write;
        $changed(pin_a_oe) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3);
    endproperty
    a_oe_write: assert property (p_oe_write) else $error("pin enable moved without write");
endmodule

bind tcmp_timer tcmp_timer_checker i_tcmp_timer_checker (.*);

// ==== tcmp_cpu_model.sv ====
`timescale 1ns/1ps
module tcmp_cpu_model
    import tcmp_pkg::*;
(
    input  wire logic        aclk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end

    ////////////////////////////////////////////////////////////
    // released address and data lines show the inverse value
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp, output logic ok);
        int n;
        ok = 1'b0;
        resp = 2'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64 && !ok; n++)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
            if (s_axi_bvalid)
            begin
                s_axi_bready <= 1'b0;
                resp = s_axi_bresp;
                ok = 1'b1;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp, output logic ok);
        int n;
        ok = 1'b0;
        d = 32'h0000_0000;
        resp = 2'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64 && !ok; n++)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
            if (s_axi_rvalid)
            begin
                s_axi_rready <= 1'b0;
                d = s_axi_rdata;
                resp = s_axi_rresp;
                ok = 1'b1;
            end
        end
    endtask

    task automatic wr16(input logic [7:0] a, input logic [15:0] v, output logic ok);
        logic [1:0] resp;
        logic       ok_hi;
        wr(ADDR_CMP_HI, {24'h00_0000, v[15:8]}, resp, ok_hi);
        wr(a, {24'h00_0000, v[7:0]}, resp, ok);
        ok = ok & ok_hi;
    endtask
endmodule

// ==== tcmp_timer_tb_top.sv ====
`timescale 1ns/1ps
module tcmp_timer_tb_top
    import tcmp_pkg::*;
;
    logic        aclk, aresetn, capture_pin, ovf_int_ack, cmpa_int_ack, cmpb_int_ack, cap_int_ack;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pin_a_out, pin_a_oe;
    logic        pin_b_out, pin_b_oe, ok;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  s_axi_wstrb, flags;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]  cm [5] = '{COM_CLEAR, COM_SET, COM_TOGGLE, COM_TOGGLE, COM_OFF};
    logic [4:0]  ocx = 5'h1A;
    int          n_mismatch = 0, checks = 0, k, n, h;

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    tcmp_timer i_tcmp_timer (.*);
    tcmp_cpu_model i_tcmp_cpu_model (.*);

    ////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic alive(input logic c);
        if (c !== 1'b1)
        begin
            n_mismatch++;
            $display("MISMATCH %0t wait ran out", $time);
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        i_tcmp_cpu_model.wr(a, v, r, ok);
        alive(ok);
    endtask

    task automatic rd(input logic [7:0] a);
        i_tcmp_cpu_model.rd(a, d, r, ok);
        alive(ok);
    endtask

    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        i_tcmp_cpu_model.wr16(a, v, ok);
        alive(ok);
    endtask

    task automatic wait_flag(input int b, input int lim);
        for (k = 0; k < lim && flags[b] !== 1'b1; k++)
            @(posedge aclk);
        alive(flags[b]);
    endtask

    // cycles between two changes of output a
    task automatic half_period(output int hp);
        logic p;
        // skip the change caused by the setting itself and one mixed interval
        repeat (2)
        begin
            p = pin_a_out;
            for (k = 0; k < 20000 && pin_a_out === p; k++)
                @(posedge aclk);
        end
        p = pin_a_out;
        for (hp = 0; hp < 20000 && pin_a_out === p; hp++)
            @(posedge aclk);
        alive(pin_a_out !== p);
    endtask

    function automatic logic [31:0] ctl(input logic [3:0] m, input logic [1:0] c, input logic [2:0] p);
        return {21'h0, p, 2'h0, c, m};
    endfunction

    ////////////////////////////////////////////////////////////
    initial
    begin
        {aresetn, capture_pin, ovf_int_ack, cmpa_int_ack, cmpb_int_ack, cap_int_ack} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ADDR_CTRL);
        chk(d, RESET_WORD);
        rd(ADDR_PORT);
        chk(d, RESET_WORD);
        wr(ADDR_CTRL, ctl(WGM_NORMAL, COM_SET, PRESC_STOP));
        wr(ADDR_STROBE, 32'h0000_0001 << STRB_FORCE_A);
        wr(ADDR_PORT, 32'h0000_000E);
        for (n = 0; n < 5; n++)
        begin
            wr(ADDR_CTRL, ctl(WGM_NORMAL, cm[n], PRESC_STOP));
            wr(ADDR_STROBE, 32'h0000_0001 << STRB_FORCE_A);
            rd(ADDR_PORT);
            chk({31'h0, d[4]}, {31'h0, ocx[n]});
            chk({28'h0, flags}, 32'h0000_0000);
            chk({28'h0, pin_b_out, pin_b_oe, pin_a_out, pin_a_oe}, {28'h0, 2'h3, ocx[n] && cm[n] != COM_OFF, 1'b1});
        end
        wr(ADDR_CTRL, ctl(WGM_CTC_CMPA, COM_OFF, PRESC_STOP));
        rd(ADDR_PORT);
        chk({31'h0, d[4]}, 32'h0000_0001);
        wr16(ADDR_CMP_A_LO, 16'h0010);
        wr16(ADDR_COUNT, 16'h0010);
        wr(ADDR_CTRL, ctl(WGM_CTC_CMPA, COM_OFF, 3'h1));
        wait_flag(FLAG_OVF, 70000);
        chk({28'h0, flags}, 32'h0000_0001);
        wait_flag(FLAG_CMPA, 40);
        rd(ADDR_COUNT);
        chk({31'h0, d <= 32'h0000_0010}, 32'h0000_0001);
        wr(ADDR_CTRL, ctl(WGM_CTC_CMPA, COM_OFF, PRESC_STOP));
        wr(ADDR_FLAGS, (32'h0000_0001 << FLAG_OVF) | (32'h0000_0001 << FLAG_CMPB));
        @(posedge aclk) cmpa_int_ack <= 1'b1;
        @(posedge aclk) cmpa_int_ack <= 1'b0;
        @(posedge aclk);
        chk({28'h0, flags}, 32'h0000_0000);
        wr16(ADDR_COUNT, 16'hFFF0);
        wr(ADDR_CTRL, ctl(WGM_NORMAL, COM_OFF, 3'h1));
        wait_flag(FLAG_OVF, 100);
        rd(ADDR_COUNT);
        chk({31'h0, d < 32'h0000_0040}, 32'h0000_0001);
        @(posedge aclk) ovf_int_ack <= 1'b1;
        @(posedge aclk) ovf_int_ack <= 1'b0;
        @(posedge aclk);
        chk({31'h0, flags[FLAG_OVF]}, 32'h0000_0000);
        wr(ADDR_CTRL, ctl(WGM_CTC_CMPA, COM_OFF, PRESC_STOP));
        wr16(ADDR_COUNT, 16'h0000);
        wr16(ADDR_CMP_A_LO, 16'h0003);
        for (n = 1; n < 3; n++)
        begin
            wr(ADDR_CTRL, ctl(WGM_CTC_CMPA, COM_TOGGLE, 3'(n)));
            half_period(h);
            chk(h, n == 1 ? 32'h0000_0004 : 32'h0000_0020);
        end
        @(posedge aclk) capture_pin <= 1'b1;
        wait_flag(FLAG_CAP, 10);
        rd(8'h40);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk(d, 32'h0000_0000);
        stop_test();
    end
endmodule
